// ### rtl/ebs_pkg.sv
// package: register map, field layout, reset values and decode codes
package ebs_pkg;
    localparam logic [7:0] ROUTE_ADDR = 8'h07;
    localparam logic [7:0] BIAS_ADDR = 8'h08;
    localparam logic [7:0] SYSCTL_ADDR = 8'h09;
    localparam logic [7:0] ROUTE_RESET = 8'hFF;
    localparam logic [7:0] BIAS_RESET = 8'h00;
    localparam logic [7:0] SYSCTL_RESET = 8'h10;
    localparam int SECOND_ROUTE_LSB = 4;
    localparam int FIRST_ROUTE_LSB = 0;
    localparam int BIAS_LEVEL_BIT = 7;
    localparam int BIAS_COMMON_BIT = 6;
    localparam int MONITOR_LSB = 5;
    localparam int CAL_COUNT_LSB = 3;
    localparam int TIMEOUT_BIT = 2;
    localparam int CHECKSUM_BIT = 1;
    localparam int STATUS_BIT = 0;
    localparam logic [3:0] CODE_INPUT_SIX = 4'h6;
    localparam logic [3:0] CODE_INPUT_SEVEN = 4'h7;
    localparam logic [3:0] CODE_INPUT_ELEVEN = 4'hB;
    localparam logic [3:0] CODE_COMMON = 4'hC;
    localparam int NUM_INPUTS = 12;
    localparam logic [4:0] CAL_ONE = 5'h01;
    localparam logic [4:0] CAL_FOUR = 5'h04;
    localparam logic [4:0] CAL_EIGHT = 5'h08;
    localparam logic [4:0] CAL_SIXTEEN = 5'h10;
endpackage

// ### rtl/ebs_route_if.sv
// interface: one current source route code and its decoded pin selects
`timescale 1ns/1ps
interface ebs_route_if;
    logic [3:0] code;
    logic [11:0] input_sel;
    logic common_sel;
    logic ref_pos_sel;
    logic ref_neg_sel;
    modport dec (input code, output input_sel, common_sel, ref_pos_sel,
        ref_neg_sel);
    modport user (output code, input input_sel, common_sel, ref_pos_sel,
        ref_neg_sel);
endinterface

// ### rtl/ebs_route_decode.sv
// module: decodes one current-source route code into pin selects
`timescale 1ns/1ps
module ebs_route_decode (
    input wire logic twelve_input_i,
    ebs_route_if.dec rt
);
    import ebs_pkg::*;
    logic valid;
    always_comb begin
        // codes above the common code leave the source floating
        valid = 1'h1;
        // eight to eleven only exist on the twelve-input part
        if (rt.code > CODE_INPUT_SEVEN && !twelve_input_i) begin
            valid = 1'h0;
        end
    end
    genvar g;
    generate
        for (g = 0; g < NUM_INPUTS; g = g + 1) begin : g_pin
            if (g == 6 || g == 7) begin : g_var
                assign rt.input_sel[g] = twelve_input_i &&
                    (rt.code == 4'(g));
            end else begin : g_fix
                assign rt.input_sel[g] = valid &&
                    (rt.code == 4'(g));
            end
        end
    endgenerate
    assign rt.ref_pos_sel = !twelve_input_i &&
        (rt.code == CODE_INPUT_SIX);
    assign rt.ref_neg_sel = !twelve_input_i &&
        (rt.code == CODE_INPUT_SEVEN);
    assign rt.common_sel = (rt.code == CODE_COMMON);
endmodule

// ### rtl/ebs_regs.sv
// module: routing, sensor bias and system control register bank
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module ebs_regs (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic twelve_input_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic [11:0] first_source_input_o,
    output logic first_source_common_o,
    output logic first_source_ref_pos_o,
    output logic first_source_ref_neg_o,
    output logic [11:0] second_source_input_o,
    output logic second_source_common_o,
    output logic second_source_ref_pos_o,
    output logic second_source_ref_neg_o,
    output logic bias_enable_o,
    output logic bias_level_select_o,
    output logic bias_to_common_input_o,
    output logic [5:0] bias_to_input_o,
    output logic [2:0] monitor_select_o,
    output logic [1:0] calibration_sample_count_o,
    output logic [4:0] calibration_samples_o,
    output logic timeout_enable_o,
    output logic checksum_enable_o,
    output logic status_prepend_enable_o
);
    import ebs_pkg::*;

    typedef struct packed {
        logic [7:0] route;
        logic [7:0] bias;
        logic [7:0] sysctl;
        logic [7:0] rdata;
        logic [4:0] cal_samples;
    } ebs_state_t;

    ebs_state_t st;
    ebs_state_t next_st;

    ebs_route_if first_rt ();
    ebs_route_if second_rt ();

    ////////////////////////////////////////////////////////////////////////
    // register writes and read return
    always_comb begin
        next_st = st;
        if (wr_i) begin
            case (addr_i)
                ROUTE_ADDR: begin
                    next_st.route = wdata_i;
                end
                BIAS_ADDR: begin
                    next_st.bias = wdata_i;
                end
                SYSCTL_ADDR: begin
                    next_st.sysctl = wdata_i;
                end
                default: begin
                end
            endcase
        end
        // read data valid only in the cycle after the strobe
        next_st.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                ROUTE_ADDR: next_st.rdata = st.route;
                BIAS_ADDR: next_st.rdata = st.bias;
                SYSCTL_ADDR: next_st.rdata = st.sysctl;
                default: next_st.rdata = 8'h00;
            endcase
        end
        // registered so the sample count is glitch free downstream
        case (next_st.sysctl[CAL_COUNT_LSB +: 2])
            2'h0: next_st.cal_samples = CAL_ONE;
            2'h1: next_st.cal_samples = CAL_FOUR;
            2'h2: next_st.cal_samples = CAL_EIGHT;
            default: next_st.cal_samples = CAL_SIXTEEN;
        endcase
        if (!rst_b_i) begin
            next_st.route = ROUTE_RESET;
            next_st.bias = BIAS_RESET;
            next_st.sysctl = SYSCTL_RESET;
            next_st.rdata = 8'h00;
            next_st.cal_samples = CAL_EIGHT;
        end
    end

    always_ff @(posedge core_clk_i) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // current source routing
    assign first_rt.code = st.route[FIRST_ROUTE_LSB +: 4];
    assign second_rt.code = st.route[SECOND_ROUTE_LSB +: 4];

    // strap assumed static; a change only alters decode, never state
    ebs_route_decode u_first_dec (
        .twelve_input_i(twelve_input_i),
        .rt(first_rt)
    );

    ebs_route_decode u_second_dec (
        .twelve_input_i(twelve_input_i),
        .rt(second_rt)
    );

    assign first_source_input_o = first_rt.input_sel;
    assign first_source_common_o = first_rt.common_sel;
    assign first_source_ref_pos_o = first_rt.ref_pos_sel;
    assign first_source_ref_neg_o = first_rt.ref_neg_sel;
    assign second_source_input_o = second_rt.input_sel;
    assign second_source_common_o = second_rt.common_sel;
    assign second_source_ref_pos_o = second_rt.ref_pos_sel;
    assign second_source_ref_neg_o = second_rt.ref_neg_sel;

    ////////////////////////////////////////////////////////////////////////
    // sensor bias
    assign bias_level_select_o = st.bias[BIAS_LEVEL_BIT];
    // independent bits, so several pins may be biased at once
    assign bias_to_common_input_o = st.bias[BIAS_COMMON_BIT];
    assign bias_to_input_o = st.bias[5:0];
    assign bias_enable_o = |st.bias[BIAS_COMMON_BIT:0];

    ////////////////////////////////////////////////////////////////////////
    // system control
    assign monitor_select_o = st.sysctl[MONITOR_LSB +: 3];
    assign calibration_sample_count_o =
        st.sysctl[CAL_COUNT_LSB +: 2];
    assign calibration_samples_o = st.cal_samples;
    assign timeout_enable_o = st.sysctl[TIMEOUT_BIT];
    assign checksum_enable_o = st.sysctl[CHECKSUM_BIT];
    assign status_prepend_enable_o = st.sysctl[STATUS_BIT];

    assign rdata_o = st.rdata;
endmodule

// ### verification/ebs_regs_monitor.sv
// checker: port-level assertions for the register bank
`timescale 1ns/1ps
module ebs_regs_monitor (
    input logic core_clk_i,
    input logic rst_b_i,
    input logic [7:0] addr_i,
    input logic [7:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    input logic [7:0] rdata_o,
    input logic [11:0] first_source_input_o,
    input logic first_source_common_o,
    input logic [11:0] second_source_input_o,
    input logic bias_enable_o,
    input logic bias_to_common_input_o,
    input logic [5:0] bias_to_input_o,
    input logic [1:0] calibration_sample_count_o,
    input logic [4:0] calibration_samples_o
);
    import ebs_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////
    property p_ben;
        bias_enable_o == |{bias_to_common_input_o, bias_to_input_o};
    endproperty
    a_ben: assert property (p_ben) else $error("bias enable");
    property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("rdata idle");
    property p_rdb; rd_i && addr_i == BIAS_ADDR |=>
        rdata_o[5:0] == bias_to_input_o; endproperty
    a_rdb: assert property (p_rdb) else $error("bias read");
    property p_rds; rd_i && addr_i == SYSCTL_ADDR |=>
        rdata_o[4:3] == calibration_sample_count_o; endproperty
    a_rds: assert property (p_rds) else $error("sys read");
    property p_cal; calibration_samples_o == (calibration_sample_count_o ==
        2'h0 ? 5'h01 : 5'h02 << calibration_sample_count_o); endproperty
    a_cal: assert property (p_cal) else $error("cal samples");
    property p_wb; wr_i && addr_i == BIAS_ADDR |=>
        bias_to_input_o == $past(wdata_i[5:0]); endproperty
    a_wb: assert property (p_wb) else $error("bias write");
    property p_com; wr_i && addr_i == ROUTE_ADDR && wdata_i[3:0] == CODE_COMMON
        |=> first_source_common_o && first_source_input_o == 12'h000;
    endproperty
    a_com: assert property (p_com) else $error("common route");
    property p_off; wr_i && addr_i == ROUTE_ADDR && wdata_i[7:4] > CODE_COMMON
        |=> second_source_input_o == 12'h000; endproperty
    a_off: assert property (p_off) else $error("route off");
endmodule
bind ebs_regs ebs_regs_monitor ebs_regs_monitor_i (.*);

// ### verification/ebs_regs_tb_top.sv
// testbench: readback rows, route decode and reset checks
`timescale 1ns/1ps
module ebs_regs_tb_top;
    import ebs_pkg::*;
    logic core_clk_i = 0, rst_b_i = 0, tw = 0, wr = 0, rd = 0;
    logic [7:0] addr = 0, wd = 0, rdat, got;
    logic [11:0] f_in, s_in;
    logic f_c, f_p, f_n, s_c, s_p, s_n, ben, blv, bcm, tmo, crc, stp;
    logic [5:0] bin;
    logic [2:0] mon;
    logic [1:0] cnt;
    logic [4:0] smp;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    localparam logic [23:0] ROWS [8] = '{24'h07A5A5, 24'h088080, 24'h084141,
        24'h083F3F, 24'h09E7E7, 24'h090B0B, 24'h09FFFF, 24'h0A5500};
    localparam logic [4:0] NSMP [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
    always #20 core_clk_i = ~core_clk_i;
    ebs_regs ebs_regs_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .twelve_input_i(tw), .addr_i(addr), .wdata_i(wd), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdat), .first_source_input_o(f_in),
        .first_source_common_o(f_c), .first_source_ref_pos_o(f_p),
        .first_source_ref_neg_o(f_n), .second_source_input_o(s_in),
        .second_source_common_o(s_c), .second_source_ref_pos_o(s_p),
        .second_source_ref_neg_o(s_n), .bias_enable_o(ben),
        .bias_level_select_o(blv), .bias_to_common_input_o(bcm),
        .bias_to_input_o(bin), .monitor_select_o(mon),
        .calibration_sample_count_o(cnt), .calibration_samples_o(smp),
        .timeout_enable_o(tmo), .checksum_enable_o(crc),
        .status_prepend_enable_o(stp));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task rreg(input logic [7:0] a);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1 got = rdat;
    endtask
    // expected pins: inputs at n+3, then common, ref pos, ref neg
    function automatic logic [14:0] dec(input logic [3:0] c, input logic t);
        dec = 15'h0000;
        if (c < 4'h6 || (t && c < 4'hC)) begin
            dec[c + 3] = 1'h1;
        end else if (c == 4'hC) begin
            dec[2] = 1'h1;
        end else if (c == 4'h6) begin
            dec[1] = 1'h1;
        end else if (c == 4'h7) begin
            dec[0] = 1'h1;
        end
    endfunction
    task chk_rst;
        rreg(ROUTE_ADDR);
        chk(got, 8'hFF);
        rreg(BIAS_ADDR);
        chk(got, 8'h00);
        rreg(SYSCTL_ADDR);
        chk(got, 8'h10);
        chk({f_in, s_in}, 24'h000000);
        chk(smp, 5'h08);
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            fail_count++;
            report_and_stop;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        chk_rst;
        $display("reset test done");
        foreach (ROWS[i]) begin
            wreg(ROWS[i][23:16], ROWS[i][15:8]);
            rreg(ROWS[i][23:16]);
            chk(got, ROWS[i][7:0]);
            if (ROWS[i][23:16] == BIAS_ADDR) begin
                chk(ben, |ROWS[i][14:8]);
                chk({blv, bcm, bin}, ROWS[i][15:8]);
            end
            if (ROWS[i][23:16] == SYSCTL_ADDR) begin
                chk({mon, cnt}, ROWS[i][15:11]);
                chk({tmo, crc, stp}, ROWS[i][10:8]);
                chk(smp, NSMP[ROWS[i][12:11]]);
            end
        end
        $display("row test done");
        // write then read in the very next cycle: the new value must already show
        wreg(BIAS_ADDR, 8'h5A);
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1 chk(rdat, 8'h5A);
        @(posedge core_clk_i);
        #1 chk(rdat, 8'h00);
        for (int t = 0; t < 2; t++) begin
            @(posedge core_clk_i);
            tw <= t[0];
            for (int c = 0; c < 16; c++) begin
                wreg(ROUTE_ADDR, {~c[3:0], c[3:0]});
                #1;
                // first source in the low nibble, second in the high one
                chk({f_in, f_c, f_p, f_n},
                    dec(c[3:0], t[0]));
                chk({s_in, s_c, s_p, s_n},
                    dec(~c[3:0], t[0]));
            end
        end
        $display("decode test done");
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        chk_rst;
        $display("second reset done");
        report_and_stop;
    end
endmodule
